//--- include/dram_ptr_pkg.sv
// Shared constants and types for the display RAM access link and its two ends.
package dram_ptr_pkg;
    localparam int COL_W = 7;
    localparam int PAGE_W = 3;
    localparam int ADDR_W = 10;
    localparam int LINE_W = 6;
    localparam int RAM_WORDS = 1024;
    localparam logic [COL_W-1:0] COL_LAST = 7'h7F;
    localparam logic [PAGE_W-1:0] PAGE_LAST = 3'h7;
    localparam logic [1:0] BUS_6800 = 2'h0;
    localparam logic [1:0] BUS_8080 = 2'h1;
    localparam logic [1:0] BUS_SERIAL = 2'h2;
    localparam logic [1:0] AM_HORIZ = 2'h0;
    localparam logic [1:0] AM_VERT = 2'h1;
    localparam logic [1:0] AM_PAGE = 2'h2;
    localparam logic [3:0] CMD_LOW_TOP = 4'h0;
    localparam logic [4:0] CMD_HIGH_TOP = 5'h02;
    localparam logic [4:0] CMD_PAGE_TOP = 5'h16;
    localparam logic [1:0] CMD_LINE_TOP = 2'h1;
    localparam logic [7:0] CMD_MODE = 8'h20;
    localparam logic [7:0] CMD_COL_WIN = 8'h21;
    localparam logic [7:0] CMD_PAGE_WIN = 8'h22;
    localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
    localparam logic [7:0] CMD_DISP_ON = 8'hAF;
    localparam int STAT_OFF_BIT = 6;
    localparam logic [2:0] SER_LAST_BIT = 3'h7;
    localparam int SER_CLK_BIT = 0;
    localparam int SER_DAT_BIT = 1;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_XFER = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam int XFER_DC_BIT = 8;
    localparam int XFER_RD_BIT = 9;
    localparam logic [1:0] HOST_DIV_LAST = 2'h3;
    localparam logic [1:0] STROBE_LAST = 2'h1;
    typedef enum logic [2:0] {CS_IDLE, CS_MODE, CS_COL_S, CS_COL_E, CS_PG_S, CS_PG_E} cmd_state_t;
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD, H_SLO, H_SHI} host_phase_t;
endpackage

//--- include/dram_link_if.sv
// Pin-level link between the host controller and the display RAM device.
`timescale 1ns/1ps
`default_nettype none
interface dram_link_if;
    logic csn_n;
    logic dc;
    logic rw_wr;
    logic e_rd;
    logic [1:0] bus_mode;
    logic [7:0] host_d;
    logic host_oe;
    logic [7:0] dev_q;
    logic dev_oe;
    logic [7:0] bus;
    // The device wins when both drive; an undriven bus reads as zero.
    assign bus = dev_oe ? dev_q : (host_oe ? host_d : 8'h00);
    modport device(input csn_n, dc, rw_wr, e_rd, bus_mode, bus, output dev_q, dev_oe);
    modport host(output csn_n, dc, rw_wr, e_rd, bus_mode, host_d, host_oe, input bus);
endinterface
`default_nettype wire

//--- rtl/dram_ptr_step.sv
// Next column and page pointer for one data access in the current addressing mode.
`timescale 1ns/1ps
`default_nettype none
module dram_ptr_step
    import dram_ptr_pkg::*;
(
    input wire logic [1:0] amode,
    input wire logic [dram_ptr_pkg::COL_W-1:0] col,
    input wire logic [dram_ptr_pkg::PAGE_W-1:0] page,
    input wire logic [dram_ptr_pkg::COL_W-1:0] col_start,
    input wire logic [dram_ptr_pkg::COL_W-1:0] col_end,
    input wire logic [dram_ptr_pkg::PAGE_W-1:0] page_start,
    input wire logic [dram_ptr_pkg::PAGE_W-1:0] page_end,
    output logic [dram_ptr_pkg::COL_W-1:0] nxt_col,
    output logic [dram_ptr_pkg::PAGE_W-1:0] nxt_page
);
    always_comb begin
        nxt_col = col;
        nxt_page = page;
        case (amode)
            AM_HORIZ: begin
                // [R12] Column then page.
                if (col == col_end) begin
                    nxt_col = col_start;
                    // [R13] Window wrap to start.
                    nxt_page = (page == page_end) ? page_start : page + 1'b1;
                end else begin
                    nxt_col = col + 1'b1;
                end
            end
            AM_VERT: begin
                // [R14] Page then column.
                if (page == page_end) begin
                    nxt_page = page_start;
                    // [R13] Window wrap to start.
                    nxt_col = (col == col_end) ? col_start : col + 1'b1;
                end else begin
                    nxt_page = page + 1'b1;
                end
            end
            default: begin
                // [R10] Column only, page kept.
                nxt_col = (col == COL_LAST) ? '0 : col + 1'b1;
            end
        endcase
    end
endmodule
`default_nettype wire

//--- rtl/dram_device.sv
// Device end: bus decode, command interpreter, access pointers and display RAM.
//
// Overview of operation
// [R01] 6800 read: host drives R/W and D/C high.
// [R02] 8080 read: host lowers RD with D/C high.
// [R03] Serial mode offers no read, only writes.
// [R04] First read after pointer set is dummy.
// [R05] Data write: R/W low, D/C high.
// [R06] D/C,R/W decode; only data accesses advance.
// [R07] 00h-0Fh load column low nibble.
// [R08] 10h-17h load column upper nibble.
// [R09] 20h parameter picks addressing mode.
// [R10] Page mode: column advances, page stays.
// [R11] B0h-B7h set page; page, low, high order.
// [R12] Horizontal: column end reloads, page advances.
// [R13] Both ends reached: reload both starts.
// [R14] Vertical: page end reloads, column advances.
// [R15] 21h start,end column window, loads pointer.
// [R16] 22h start,end page window, loads pointer.
// [R17] Host programs windows before horizontal/vertical access.
// [R18] 40h-7Fh set six-bit display start line.
// [R19] Page commands take low three bits.
// [R20] Status bit 6 is display off.
// [R21] Byte at page,column; 128 columns, 8 pages.
// [R22] Parameters consumed in order, not executed.
`timescale 1ns/1ps
`default_nettype none
module dram_device
    import dram_ptr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    dram_link_if.device link,
    input wire logic [dram_ptr_pkg::ADDR_W-1:0] scan_addr,
    output logic [7:0] scan_data,
    output logic [dram_ptr_pkg::LINE_W-1:0] start_line,
    output logic display_off
);
    import dram_ptr_pkg::*;

    typedef struct packed {
        logic cs1_n;
        logic cs2_n;
        logic dc1;
        logic dc2;
        logic rw1;
        logic rw2;
        logic en1;
        logic en2;
        logic [1:0] mode1;
        logic [1:0] mode2;
        logic [7:0] d1;
        logic [7:0] d2;
        logic act;
        logic rd_cyc;
        logic rd_dc;
        logic sclk_prev;
        logic [7:0] shf;
        logic [2:0] bits;
        cmd_state_t cst;
        logic [1:0] amode;
        logic [COL_W-1:0] col;
        logic [PAGE_W-1:0] page;
        logic [COL_W-1:0] col_start;
        logic [COL_W-1:0] col_end;
        logic [PAGE_W-1:0] page_start;
        logic [PAGE_W-1:0] page_end;
        logic [LINE_W-1:0] line;
        logic disp_off;
        logic [7:0] rd_latch;
        logic [7:0] dq;
        logic dq_oe;
    } dev_state_t;

    localparam dev_state_t DEV_RESET = '{
        cs1_n: 1'b1, cs2_n: 1'b1, rw1: 1'b1, rw2: 1'b1, cst: CS_IDLE, amode: AM_PAGE,
        col_end: COL_LAST, page_end: PAGE_LAST, disp_off: 1'b1, default: '0};

    dev_state_t st_ff;
    dev_state_t nxt_st;
    logic [7:0] ram [RAM_WORDS];
    logic [7:0] scan_data_ff;
    logic act_now;
    logic rd_now;
    logic ev_byte;
    logic ev_dc;
    logic [7:0] ev_data;
    logic ram_we;
    logic [ADDR_W-1:0] ptr_addr;
    logic [COL_W-1:0] step_col;
    logic [PAGE_W-1:0] step_page;

    // [R21] Page selects the row of bytes.
    assign ptr_addr = {st_ff.page, st_ff.col};

    dram_ptr_step u_step (
        .amode(st_ff.amode),
        .col(st_ff.col),
        .page(st_ff.page),
        .col_start(st_ff.col_start),
        .col_end(st_ff.col_end),
        .page_start(st_ff.page_start),
        .page_end(st_ff.page_end),
        .nxt_col(step_col),
        .nxt_page(step_page)
    );

    always_comb begin
        nxt_st = st_ff;
        ev_byte = 1'b0;
        ev_dc = 1'b0;
        ev_data = st_ff.d2;
        ram_we = 1'b0;
        act_now = 1'b0;
        rd_now = 1'b0;
        nxt_st.cs1_n = link.csn_n;
        nxt_st.cs2_n = st_ff.cs1_n;
        nxt_st.dc1 = link.dc;
        nxt_st.dc2 = st_ff.dc1;
        nxt_st.rw1 = link.rw_wr;
        nxt_st.rw2 = st_ff.rw1;
        nxt_st.en1 = link.e_rd;
        nxt_st.en2 = st_ff.en1;
        nxt_st.mode1 = link.bus_mode;
        nxt_st.mode2 = st_ff.mode1;
        nxt_st.d1 = link.bus;
        nxt_st.d2 = st_ff.d1;
        case (st_ff.mode2)
            BUS_6800: begin
                // [R01] Strobe E high; R/W high reads.
                act_now = !st_ff.cs2_n && st_ff.en2;
                rd_now = st_ff.rw2;
            end
            BUS_8080: begin
                // [R02] RD low reads, WR low writes.
                act_now = !st_ff.cs2_n && (!st_ff.rw2 || !st_ff.en2);
                rd_now = !st_ff.en2;
            end
            default: begin
                act_now = 1'b0;
                rd_now = 1'b0;
            end
        endcase
        nxt_st.act = act_now;
        if (act_now && !st_ff.act) begin
            nxt_st.rd_cyc = rd_now;
            nxt_st.rd_dc = st_ff.dc2;
            nxt_st.dq_oe = rd_now;
            // [R20] Status shows only display off.
            nxt_st.dq = st_ff.dc2 ? st_ff.rd_latch : 8'h00;
            nxt_st.dq[STAT_OFF_BIT] = st_ff.dc2 ? st_ff.rd_latch[STAT_OFF_BIT] : st_ff.disp_off;
        end
        if (!act_now && st_ff.act) begin
            nxt_st.dq_oe = 1'b0;
            if (!st_ff.rd_cyc) begin
                ev_byte = 1'b1;
                ev_dc = st_ff.dc2;
            end else if (st_ff.rd_dc) begin
                // [R04] Latch refills after the byte is shown.
                nxt_st.rd_latch = ram[ptr_addr];
                // [R06] Data read advances the pointer.
                nxt_st.col = step_col;
                nxt_st.page = step_page;
            end
        end
        // [R03] Serial bytes are always writes.
        if (st_ff.mode2 == BUS_SERIAL) begin
            nxt_st.sclk_prev = st_ff.d2[SER_CLK_BIT];
            if (st_ff.cs2_n) begin
                nxt_st.bits = '0;
            end else if (st_ff.d2[SER_CLK_BIT] && !st_ff.sclk_prev) begin
                nxt_st.shf = {st_ff.shf[6:0], st_ff.d2[SER_DAT_BIT]};
                nxt_st.bits = st_ff.bits + 1'b1;
                if (st_ff.bits == SER_LAST_BIT) begin
                    ev_byte = 1'b1;
                    ev_dc = st_ff.dc2;
                    ev_data = {st_ff.shf[6:0], st_ff.d2[SER_DAT_BIT]};
                end
            end
        end
        if (ev_byte && ev_dc) begin
            // [R05] Data write stores and advances.
            ram_we = 1'b1;
            nxt_st.col = step_col;
            nxt_st.page = step_page;
        end else if (ev_byte) begin
            // [R22] Parameter bytes bypass the decoder.
            case (st_ff.cst)
                CS_MODE: begin
                    // [R09] Addressing mode parameter.
                    nxt_st.amode = ev_data[1:0];
                    nxt_st.cst = CS_IDLE;
                end
                CS_COL_S: begin
                    nxt_st.col_start = ev_data[COL_W-1:0];
                    nxt_st.cst = CS_COL_E;
                end
                CS_COL_E: begin
                    // [R15] Window end, pointer to start.
                    nxt_st.col_end = ev_data[COL_W-1:0];
                    nxt_st.col = st_ff.col_start;
                    nxt_st.cst = CS_IDLE;
                end
                CS_PG_S: begin
                    nxt_st.page_start = ev_data[PAGE_W-1:0];
                    nxt_st.cst = CS_PG_E;
                end
                CS_PG_E: begin
                    // [R16] Window end, pointer to start.
                    nxt_st.page_end = ev_data[PAGE_W-1:0];
                    nxt_st.page = st_ff.page_start;
                    nxt_st.cst = CS_IDLE;
                end
                default: begin
                    if (ev_data[7:4] == CMD_LOW_TOP) begin
                        // [R07] Lower column nibble.
                        nxt_st.col[3:0] = ev_data[3:0];
                    end else if (ev_data[7:3] == CMD_HIGH_TOP) begin
                        // [R08] Upper column bits.
                        nxt_st.col[COL_W-1:4] = ev_data[2:0];
                    end else if (ev_data[7:3] == CMD_PAGE_TOP) begin
                        // [R11] [R19] Page pointer from low bits.
                        nxt_st.page = ev_data[PAGE_W-1:0];
                    end else if (ev_data[7:6] == CMD_LINE_TOP) begin
                        // [R18] Display start line.
                        nxt_st.line = ev_data[LINE_W-1:0];
                    end else if (ev_data == CMD_MODE) begin
                        nxt_st.cst = CS_MODE;
                    end else if (ev_data == CMD_COL_WIN) begin
                        nxt_st.cst = CS_COL_S;
                    end else if (ev_data == CMD_PAGE_WIN) begin
                        nxt_st.cst = CS_PG_S;
                    end else if (ev_data == CMD_DISP_OFF) begin
                        nxt_st.disp_off = 1'b1;
                    end else if (ev_data == CMD_DISP_ON) begin
                        nxt_st.disp_off = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= DEV_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // The array has no reset; contents are undefined until written.
    always_ff @(posedge sys_clk) begin
        if (ram_we) begin
            ram[ptr_addr] <= ev_data;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scan_data_ff <= 8'h00;
        end else begin
            scan_data_ff <= ram[scan_addr];
        end
    end

    assign link.dev_q = st_ff.dq;
    assign link.dev_oe = st_ff.dq_oe;
    assign scan_data = scan_data_ff;
    assign start_line = st_ff.line;
    assign display_off = st_ff.disp_off;
endmodule
`default_nettype wire

//--- rtl/dram_host.sv
// Host end: APB register slave that drives byte transfers onto the display link.
`timescale 1ns/1ps
`default_nettype none
module dram_host
    import dram_ptr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    dram_link_if.host link
);
    import dram_ptr_pkg::*;

    typedef struct packed {
        logic [1:0] div;
        logic [1:0] cnt;
        logic [2:0] bits;
        host_phase_t ph;
        logic busy;
        logic [1:0] bmode;
        logic [7:0] byte_q;
        logic dc_q;
        logic rd_q;
        logic [7:0] rdata;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic csn_n;
        logic dc;
        logic rw_wr;
        logic e_rd;
        logic [7:0] hd;
        logic hd_oe;
    } host_state_t;

    localparam host_state_t HOST_RESET = '{
        ph: H_IDLE, bmode: BUS_6800, csn_n: 1'b1, rw_wr: 1'b1, default: '0};

    host_state_t st_ff;
    host_state_t nxt_st;
    logic tick;
    logic serial;

    assign serial = (st_ff.bmode == BUS_SERIAL);
    assign tick = (st_ff.div == HOST_DIV_LAST);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.div = tick ? 2'h0 : st_ff.div + 1'b1;
        if (psel && penable && !st_ff.pready) begin
            nxt_st.pready = 1'b1;
            nxt_st.pslverr = !(paddr == REG_CTRL || paddr == REG_XFER || paddr == REG_STAT);
            case (paddr)
                REG_CTRL: nxt_st.prdata = {30'h0, st_ff.bmode};
                REG_XFER: nxt_st.prdata = {22'h0, st_ff.rd_q, st_ff.dc_q, st_ff.byte_q};
                REG_STAT: nxt_st.prdata = {16'h0, st_ff.rdata, 7'h0, st_ff.busy};
                default: nxt_st.prdata = 32'h0000_0000;
            endcase
        end
        if (psel && penable && st_ff.pready) begin
            nxt_st.pready = 1'b0;
            nxt_st.pslverr = 1'b0;
            // Writes while a transfer runs are dropped so pins never glitch mid-byte.
            if (pwrite && !st_ff.busy) begin
                if (paddr == REG_CTRL) begin
                    nxt_st.bmode = pwdata[1:0];
                end else if (paddr == REG_XFER) begin
                    nxt_st.busy = 1'b1;
                    nxt_st.ph = H_SETUP;
                    nxt_st.byte_q = pwdata[7:0];
                    nxt_st.dc_q = pwdata[XFER_DC_BIT];
                    // [R03] Serial reads become writes.
                    nxt_st.rd_q = pwdata[XFER_RD_BIT] && !serial;
                end
            end
        end
        if (st_ff.ph == H_IDLE) begin
            nxt_st.e_rd = (st_ff.bmode != BUS_6800);
            nxt_st.rw_wr = 1'b1;
        end else if (tick) begin
            case (st_ff.ph)
                H_SETUP: begin
                    nxt_st.csn_n = 1'b0;
                    nxt_st.dc = st_ff.dc_q;
                    nxt_st.hd_oe = !st_ff.rd_q;
                    nxt_st.cnt = 2'h0;
                    if (serial) begin
                        nxt_st.hd = 8'h00;
                        nxt_st.hd[SER_DAT_BIT] = st_ff.byte_q[7];
                        nxt_st.bits = 3'h0;
                        nxt_st.ph = H_SLO;
                    end else begin
                        // [R05] 6800 write holds R/W low, D/C high for data.
                        nxt_st.hd = st_ff.byte_q;
                        nxt_st.rw_wr = (st_ff.bmode == BUS_6800) ? st_ff.rd_q : 1'b1;
                        nxt_st.ph = H_STROBE;
                    end
                end
                H_STROBE: begin
                    if (st_ff.cnt == 2'h0) begin
                        // [R01] [R02] Strobe for read or write.
                        if (st_ff.bmode == BUS_6800) begin
                            nxt_st.e_rd = 1'b1;
                        end else if (st_ff.rd_q) begin
                            nxt_st.e_rd = 1'b0;
                        end else begin
                            nxt_st.rw_wr = 1'b0;
                        end
                    end
                    nxt_st.cnt = st_ff.cnt + 1'b1;
                    if (st_ff.cnt == STROBE_LAST + 1'b1) begin
                        nxt_st.rdata = st_ff.rd_q ? link.bus : st_ff.rdata;
                        nxt_st.e_rd = (st_ff.bmode != BUS_6800);
                        nxt_st.rw_wr = (st_ff.bmode == BUS_6800) ? st_ff.rd_q : 1'b1;
                        nxt_st.ph = H_HOLD;
                    end
                end
                H_SLO: begin
                    nxt_st.hd[SER_CLK_BIT] = 1'b1;
                    nxt_st.ph = H_SHI;
                end
                H_SHI: begin
                    nxt_st.hd[SER_CLK_BIT] = 1'b0;
                    if (st_ff.bits == SER_LAST_BIT) begin
                        nxt_st.ph = H_HOLD;
                    end else begin
                        nxt_st.bits = st_ff.bits + 1'b1;
                        nxt_st.byte_q = {st_ff.byte_q[6:0], 1'b0};
                        nxt_st.hd[SER_DAT_BIT] = st_ff.byte_q[6];
                        nxt_st.ph = H_SLO;
                    end
                end
                H_HOLD: begin
                    nxt_st.csn_n = 1'b1;
                    nxt_st.hd_oe = 1'b0;
                    nxt_st.busy = 1'b0;
                    nxt_st.ph = H_IDLE;
                end
                default: nxt_st.ph = H_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= HOST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign link.csn_n = st_ff.csn_n;
    assign link.dc = st_ff.dc;
    assign link.rw_wr = st_ff.rw_wr;
    assign link.e_rd = st_ff.e_rd;
    assign link.bus_mode = st_ff.bmode;
    assign link.host_d = st_ff.hd;
    assign link.host_oe = st_ff.hd_oe;
endmodule
`default_nettype wire

//--- verif/dram_link_properties.sv
// Link checker: timing relations between the host and device ends.
`timescale 1ns/1ps
`default_nettype none
module dram_link_properties
    import dram_ptr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic csn_n,
    input wire logic dc,
    input wire logic rw_wr,
    input wire logic e_rd,
    input wire logic [1:0] bus_mode,
    input wire logic host_oe,
    input wire logic dev_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_serial_quiet;
        !csn_n && bus_mode == BUS_SERIAL |-> !dev_oe;
    endproperty
    a_serial_quiet: assert property (p_serial_quiet)
        else $error("Device drove the bus in serial mode.");
    property p_oe_read;
        $rose(dev_oe) |-> !csn_n && (bus_mode == BUS_8080 ? !e_rd : rw_wr);
    endproperty
    a_oe_read: assert property (p_oe_read)
        else $error("Device drove the bus outside a read.");
    property p_oe_ends;
        $rose(csn_n) |-> ##[0:8] !dev_oe;
    endproperty
    a_oe_ends: assert property (p_oe_ends)
        else $error("Device kept the bus after the access.");
    property p_wr6800;
        !csn_n && bus_mode == BUS_6800 && host_oe |-> !rw_wr;
    endproperty
    a_wr6800: assert property (p_wr6800)
        else $error("Host drove data without a write select.");
    property p_wr8080;
        !csn_n && bus_mode == BUS_8080 && !rw_wr |-> host_oe;
    endproperty
    a_wr8080: assert property (p_wr8080)
        else $error("Write strobe without host data.");
    property p_rd8080;
        !csn_n && bus_mode == BUS_8080 && !e_rd |-> !host_oe && rw_wr;
    endproperty
    a_rd8080: assert property (p_rd8080)
        else $error("Read strobe while host drives.");
    property p_dc_stable;
        !csn_n && !$past(csn_n) |-> $stable(dc);
    endproperty
    a_dc_stable: assert property (p_dc_stable)
        else $error("Data select moved inside an access.");
    property p_strobe;
        $rose(e_rd) && bus_mode == BUS_6800 |-> (e_rd && !csn_n) [*6];
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("Enable strobe too short.");
endmodule
`default_nettype wire

//--- verif/tb.sv
// Bench driving the host over APB and checking the device behind the link.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dram_ptr_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst;
    logic [7:0] paddr;
    logic psel, penable, pwrite, pready, pslverr, er, display_off;
    logic [31:0] pwdata, prdata, rd;
    logic [ADDR_W-1:0] scan_addr;
    logic [7:0] scan_data, q, m, v, i;
    logic [LINE_W-1:0] start_line;
    int err_count, tests_run, cyc;
    dram_link_if link();
    dram_host dram_host_inst(.sys_clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .link(link));
    dram_device dram_device_inst(.sys_clk, .sys_rst, .link(link), .scan_addr, .scan_data,
        .start_line, .display_off);
    dram_link_properties dram_link_properties_inst(.sys_clk, .sys_rst, .csn_n(link.csn_n),
        .dc(link.dc), .rw_wr(link.rw_wr), .e_rd(link.e_rd), .bus_mode(link.bus_mode),
        .host_oe(link.host_oe), .dev_oe(link.dev_oe));
    always #4 sys_clk = ~sys_clk;
    task stop_test();
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // The answer is taken only at the edge where pready is seen high.
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge sys_clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task xfer(input logic d, input logic r, input logic [7:0] b);
        apb(REG_XFER, 1'b1, {22'h00_0000, r, d, b});
        do apb(REG_STAT, 1'b0, '0); while (rd[0] !== 1'b0);
        q = rd[15:8];
    endtask
    task cmd(input logic [7:0] b);
        xfer(1'b0, 1'b0, b);
    endtask
    task ram(input logic [2:0] p, input logic [6:0] c, input logic [7:0] e);
        @(posedge sys_clk);
        scan_addr <= {p, c};
        repeat (2) @(posedge sys_clk);
        chk(scan_data, e);
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        scan_addr = '0;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        chk(display_off, 1'b1);
        chk(start_line, 6'h00);
        apb(8'h0C, 1'b0, '0);
        chk(er, 1'b1);
        for (m = 0; m < 3; m++) begin
            apb(REG_CTRL, 1'b1, {24'h00_0000, m});
            cmd(CMD_DISP_ON);
            chk(display_off, 1'b0);
            if (m < 2) begin
                xfer(1'b0, 1'b1, 8'h00);
                chk(q, 8'h00);
                cmd(CMD_DISP_OFF);
                xfer(1'b0, 1'b1, 8'h00);
                chk(q, 8'h40);
            end
            cmd(8'hB5 + m);
            cmd(8'h0E);
            cmd(8'h17);
            // Serial forces the read bit off, so this lands as a write.
            xfer(1'b1, m == 2, 8'hA0 + m);
            xfer(1'b1, 1'b0, 8'hB0 + m);
            xfer(1'b1, 1'b0, 8'hC0 + m);
            ram(m[2:0] + 3'h5, 7'h7E, 8'hA0 + m);
            ram(m[2:0] + 3'h5, 7'h7F, 8'hB0 + m);
            ram(m[2:0] + 3'h5, 7'h00, 8'hC0 + m);
            if (m < 2) begin
                cmd(8'hB5 + m);
                cmd(8'h0E);
                cmd(8'h17);
                xfer(1'b1, 1'b1, 8'h00);
                xfer(1'b1, 1'b1, 8'h00);
                chk(q, 8'hA0 + m);
                xfer(1'b1, 1'b1, 8'h00);
                chk(q, 8'hB0 + m);
            end
        end
        for (v = 0; v < 2; v++) begin
            cmd(CMD_MODE);
            cmd(v);
            cmd(CMD_COL_WIN);
            cmd(8'h7E);
            cmd(8'h7F);
            cmd(CMD_PAGE_WIN);
            cmd(8'h06);
            cmd(8'h07);
            for (i = 0; i < 5; i++)
                xfer(1'b1, 1'b0, 8'h50 + 8'h08 * v + i);
            for (i = 1; i < 4; i++)
                ram(3'h6 + (v[0] ? i[0] : i[1]), 7'h7E + (v[0] ? i[1] : i[0]),
                    8'h50 + 8'h08 * v + i);
            ram(3'h6, 7'h7E, 8'h54 + 8'h08 * v);
        end
        cmd(8'h7F);
        chk(start_line, 6'h3F);
        cmd(CMD_MODE);
        cmd(8'h7D);
        chk(start_line, 6'h3F);
        cmd(8'h40);
        chk(start_line, 6'h00);
        stop_test();
    end
endmodule
`default_nettype wire
